// ---- verilog/ptt_timebase.sv ----
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
// How it works
// RL1 - fifteen-stage divider, eight selectable taps
// RL2 - run clear holds chain at zero
// RL3 - run set counts from zero
// RL4 - rollover at selected tap sets flag
// RL5 - irq when flag and enable set
// RL6 - first tick half period, then full
// RL7 - ack one clears flag, zero nothing
// RL8 - ack bit reads zero, stores nothing
// RL9 - flag read-only, set by rollover only
// RL10 - taps 0..3 give 32768/8192/2048/128
// RL11 - taps 4,5 give 64 and 32
// RL12 - taps 6,7 give 16 and 8
// RL13 - external clock used when enabled
// RL14 - software changes tap only while stopped
// RL15 - wait mode counts, register blocked
// RL16 - stop mode counts only with keep-osc
// RL17 - register blocked during stop mode
// RL18 - reset clears enables, chain zero
// RL19 - software disables unused timebase before sleep
// RL20 - irq level holds until ack
module ptt_timebase
  import ptt_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clocks and clock control
  input  wire logic        external_clock_in,
  input  wire logic        internal_clock_in,
  input  wire logic        external_clock_on,
  // low-power state
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        osc_keep_in_stop,
  // cpu interrupt
  output logic             tick_irq
);

  ptt_src_if sif ();

  logic [14:0] chain_r;
  logic [14:0] chain_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        ie_r;
  logic        ie_nxt;
  logic [2:0]  tap_r;
  logic [2:0]  tap_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        slverr_r;
  logic        slverr_nxt;
  logic        access;
  logic        blocked;
  logic        hit_ctl;
  logic        hit_sts;
  logic        wr_ctl;
  logic        active;
  logic        step;
  logic        rollover;
  logic [15:0] tap_bits;
  logic [3:0]  tap_idx;

  // ------------------------------------------------------------
  // source clock selection
  // ------------------------------------------------------------
  ptt_src_sel u_src (
    .pclk              (pclk),
    .presetn           (presetn),
    .external_clock_in (external_clock_in),
    .internal_clock_in (internal_clock_in),
    .external_clock_on (external_clock_on),
    .sif               (sif)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // RL15 - no cpu access in wait
  // RL17 - no cpu access in stop
  assign blocked = wait_mode | stop_mode;
  assign access  = psel & penable;
  assign hit_ctl = (paddr == PTT_TICK_CONTROL_OFS);
  assign hit_sts = (paddr == PTT_STATUS_OFS);
  assign wr_ctl  = access & pwrite & hit_ctl & pstrb[0] & ~blocked;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = slverr_r;

  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  // RL16 - stop halts chain unless kept
  assign active = run_r & ~(stop_mode & ~osc_keep_in_stop);
  assign step   = active & sif.tick_src_edge;

  // RL10 - tap to stage mapping
  // RL11 - codes 100 and 101
  // RL12 - codes 110 and 111
  always_comb
  begin
    case (tap_r)
      3'h0:    tap_idx = 4'hE;
      3'h1:    tap_idx = 4'hC;
      3'h2:    tap_idx = 4'hA;
      3'h3:    tap_idx = 4'h6;
      3'h4:    tap_idx = 4'h5;
      3'h5:    tap_idx = 4'h4;
      3'h6:    tap_idx = 4'h3;
      default: tap_idx = 4'h2;
    endcase
  end

  // RL1 - one rising-edge detect per stage
  genvar g;
  generate
    for (g = 0; g < PTT_STAGES; g++)
    begin : g_tap
      assign tap_bits[g] = ~chain_r[g] & chain_nxt[g];
    end
  endgenerate
  assign tap_bits[15] = 1'b0;

  // RL4 - stage N rises every 2^(N+1) steps
  // rising edge, not falling: first rise after 2^N steps
  // RL6 - first tick lands at half period
  assign rollover = step & tap_bits[tap_idx];

  always_comb
  begin
    chain_nxt = chain_r;
    // RL2 - disabled chain held at zero
    if (!run_r)
    begin
      chain_nxt = PTT_CHAIN_RESET;
    end
    // RL3 - counting begins from zero
    else if (step)
    begin
      chain_nxt = chain_r + 15'h0001;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_comb
  begin
    run_nxt  = run_r;
    ie_nxt   = ie_r;
    tap_nxt  = tap_r;
    flag_nxt = flag_r;
    if (wr_ctl)
    begin
      run_nxt = pwdata[PTT_BIT_RUN];
      ie_nxt  = pwdata[PTT_BIT_IE];
      // RL14 - tap writable only while stopped
      if (!run_r)
      begin
        tap_nxt = pwdata[PTT_BIT_TAP_HI:PTT_BIT_TAP_LO];
      end
      // RL7 - ack of one clears flag
      if (pwdata[PTT_BIT_ACK])
      begin
        flag_nxt = 1'b0;
      end
    end
    // RL9 - flag cleared with the enable
    if (!run_r)
    begin
      flag_nxt = 1'b0;
    end
    // RL9 - only a rollover sets it, set wins
    if (rollover)
    begin
      flag_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    slverr_nxt = 1'b0;
    if (psel && !penable)
    begin
      if (blocked || !(hit_ctl || hit_sts))
      begin
        slverr_nxt = 1'b1;
      end
      else if (!pwrite && hit_ctl)
      begin
        // RL8 - ack position always reads zero
        prdata_nxt[PTT_BIT_FLAG]                   = flag_r;
        prdata_nxt[PTT_BIT_TAP_HI:PTT_BIT_TAP_LO]  = tap_r;
        prdata_nxt[PTT_BIT_IE]                     = ie_r;
        prdata_nxt[PTT_BIT_RUN]                    = run_r;
      end
      else if (!pwrite)
      begin
        prdata_nxt[PTT_BIT_SRC_EXT] = sif.src_is_ext;
        prdata_nxt[PTT_BIT_ACTIVE]  = active;
        prdata_nxt[PTT_BIT_BLOCKED] = blocked;
      end
    end
    else if (access)
    begin
      prdata_nxt = prdata_r;
      slverr_nxt = slverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // RL18 - reset disables, chain zero
      chain_r  <= PTT_CHAIN_RESET;
      run_r    <= 1'b0;
      ie_r     <= 1'b0;
      tap_r    <= PTT_TAP_RESET;
      flag_r   <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else
    begin
      chain_r  <= chain_nxt;
      run_r    <= run_nxt;
      ie_r     <= ie_nxt;
      tap_r    <= tap_nxt;
      flag_r   <= flag_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // RL5 - irq from flag and enable
  // RL20 - level until ack or disable
  assign tick_irq = flag_r & ie_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_chain_held_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !run_r |=> chain_r == 15'h0000)
    else $error("chain not zero while disabled");

  a_flag_from_roll: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    $rose(flag_r) |-> $past(rollover))
    else $error("flag rose without rollover");

  a_roll_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    rollover |=> flag_r)
    else $error("rollover did not set flag");

  a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    wr_ctl && pwdata[PTT_BIT_ACK] && !rollover |=> !flag_r)
    else $error("ack did not clear flag");

  a_ack_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    wr_ctl && !pwdata[PTT_BIT_ACK] && run_r && flag_r |=> flag_r)
    else $error("ack zero cleared flag");

  a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    !prdata[PTT_BIT_ACK])
    else $error("ack bit read as one");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    tick_irq == (flag_r && ie_r))
    else $error("irq does not follow flag and enable");

  a_irq_holds: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    tick_irq && !wr_ctl && run_r |=> tick_irq)
    else $error("irq dropped without ack");

  a_blocked_write: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    blocked |-> !wr_ctl)
    else $error("register written while asleep");

  a_stop_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    stop_mode && !osc_keep_in_stop && run_r |=> $stable(chain_r))
    else $error("chain moved in stop");

  a_step_count: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    run_r && step |=> chain_r == $past(chain_r) + 15'h0001)
    else $error("chain did not increment");

  a_tap_locked: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    run_r |=> $stable(tap_r))
    else $error("tap changed while running");

endmodule // ptt_timebase

// ---- verilog/ptt_pkg.sv ----
package ptt_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] PTT_TICK_CONTROL_OFS = 12'h000;
  localparam logic [11:0] PTT_STATUS_OFS       = 12'h004;

  // ------------------------------------------------------------
  // tick_control field positions
  // ------------------------------------------------------------
  localparam int PTT_BIT_FLAG   = 7;
  localparam int PTT_BIT_TAP_HI = 6;
  localparam int PTT_BIT_TAP_LO = 4;
  localparam int PTT_BIT_ACK    = 3;
  localparam int PTT_BIT_IE     = 2;
  localparam int PTT_BIT_RUN    = 1;

  // status register bit positions
  localparam int PTT_BIT_SRC_EXT = 0;
  localparam int PTT_BIT_ACTIVE  = 1;
  localparam int PTT_BIT_BLOCKED = 2;

  // ------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------
  localparam int          PTT_STAGES      = 15;
  localparam logic [2:0]  PTT_TAP_RESET   = 3'h0;
  localparam logic [14:0] PTT_CHAIN_RESET = 15'h0000;

  typedef enum logic [1:0] {
    PTT_SRC_IDLE = 2'b00,
    PTT_SRC_HI   = 2'b01,
    PTT_SRC_LO   = 2'b10
  } ptt_edge_t;

endpackage

// ---- verilog/ptt_src_if.sv ----
`timescale 1ns/10ps
interface ptt_src_if;
  logic tick_src_edge;
  logic src_is_ext;
  modport src (output tick_src_edge, output src_is_ext);
  modport dst (input tick_src_edge, input src_is_ext);
endinterface

// ---- verilog/ptt_src_sel.sv ----
`timescale 1ns/10ps
// selects the tick source clock and turns its rising edges into pclk pulses
module ptt_src_sel
  import ptt_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // clock pins
  input  wire logic external_clock_in,
  input  wire logic internal_clock_in,
  input  wire logic external_clock_on,
  // toward the divider
  ptt_src_if.src    sif
);

  logic [2:0] ext_sync_r;
  logic [2:0] int_sync_r;
  logic [2:0] ext_sync_nxt;
  logic [2:0] int_sync_nxt;
  logic       ext_lvl_r;
  logic       ext_lvl_nxt;
  logic       int_lvl_r;
  logic       int_lvl_nxt;
  logic       ext_rise;
  logic       int_rise;

  // ------------------------------------------------------------
  // synchronisers, a change counts once stages 2 and 3 agree
  // ------------------------------------------------------------
  always_comb
  begin
    ext_sync_nxt = {ext_sync_r[1:0], external_clock_in};
    int_sync_nxt = {int_sync_r[1:0], internal_clock_in};
    ext_lvl_nxt  = (ext_sync_r[1] == ext_sync_r[2]) ? ext_sync_r[2] : ext_lvl_r;
    int_lvl_nxt  = (int_sync_r[1] == int_sync_r[2]) ? int_sync_r[2] : int_lvl_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync_r <= 3'h0;
      int_sync_r <= 3'h0;
      ext_lvl_r  <= 1'b0;
      int_lvl_r  <= 1'b0;
    end
    else
    begin
      ext_sync_r <= ext_sync_nxt;
      int_sync_r <= int_sync_nxt;
      ext_lvl_r  <= ext_lvl_nxt;
      int_lvl_r  <= int_lvl_nxt;
    end
  end

  assign ext_rise = ext_lvl_nxt & ~ext_lvl_r;
  assign int_rise = int_lvl_nxt & ~int_lvl_r;

  // RL13 - external wins when on
  assign sif.tick_src_edge = external_clock_on ? ext_rise : int_rise;
  assign sif.src_is_ext    = external_clock_on;

endmodule // ptt_src_sel

// ---- dv/ptt_timebase_test.sv ----
`timescale 1ns/10ps
module ptt_timebase_test;
  import ptt_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        external_clock_in = 1'b0;
  logic        internal_clock_in = 1'b0;
  logic        external_clock_on = 1'b0;
  logic        wait_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        osc_keep_in_stop = 1'b0;
  logic        tick_irq;
  logic [31:0] rd;
  logic        er;
  int          cyc = 0;
  int          icnt = 0;
  int          n_errors = 0;
  int          n_checks = 0;

  ptt_timebase uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_clock_in(external_clock_in),
    .internal_clock_in(internal_clock_in), .external_clock_on(external_clock_on),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .osc_keep_in_stop(osc_keep_in_stop),
    .tick_irq(tick_irq));

  always #20 pclk = ~pclk;

  // ----------------------------------------
  // source clocks: internal 6 pclk, external 8 pclk
  // ----------------------------------------
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    icnt <= (icnt == 2) ? 0 : icnt + 1;
    if (icnt == 2) internal_clock_in <= ~internal_clock_in;
    if (cyc[1:0] == 2'h3) external_clock_in <= ~external_clock_in;
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkr(input int v, input int lo, input int hi, input string m);
    n_checks++;
    if (v < lo || v > hi)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask

  // waits are bounded; running out ends the run
  task automatic tmo(input int n, input int b);
    if (n >= b)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      results();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    tmo(n, 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wirq(input int b);
    int n = 0;
    while (tick_irq !== 1'b1 && n < b)
    begin
      @(posedge pclk);
      n++;
    end
    tmo(n, b);
  endtask

  // one tap: first tick, flag, masking, ack and exact period
  task automatic run_tap(input int tap, input int sp);
    int          div;
    int          t0;
    int          t1;
    logic [31:0] cfg;
    case (tap)
      0:       div = 32768;
      1:       div = 8192;
      2:       div = 2048;
      default: div = 1 << (10 - tap);
    endcase
    cfg = 32'(tap) << 4;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, cfg);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, cfg, "stopped");
    apb(1'b1, 12'h000, cfg | 32'h6);
    t0 = cyc;
    wirq(div * sp + 50);
    t1 = cyc;
    chkr(t1 - t0, (div / 2 - 1) * sp, div / 2 * sp + 10, "first tick");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, cfg | 32'h86, "flag set");
    apb(1'b1, 12'h000, cfg | 32'h6);
    @(posedge pclk);
    chk(tick_irq, 1'b1, "ack zero");
    apb(1'b1, 12'h000, cfg | 32'h2);
    repeat (2) @(posedge pclk);
    chk(tick_irq, 1'b0, "masked");
    apb(1'b1, 12'h000, cfg | 32'hE);
    repeat (2) @(posedge pclk);
    chk(tick_irq, 1'b0, "acked");
    wirq(div * sp + 50);
    chk(cyc - t1, div * sp, "period");
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "reset value");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1, "unmapped");
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, 12'h000, 32'(k) << 4);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'(k) << 4, "tap field");
    end
    pstrb <= 4'hE;
    apb(1'b1, 12'h000, 32'h2);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h70, "lane off");
    apb(1'b1, 12'h000, 32'h32);
    apb(1'b1, 12'h000, 32'h72);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h32, "tap kept");
    $display("registers test done");
    for (int t = 7; t >= 2; t--)
      run_tap(t, 6);
    $display("tap test done");
    external_clock_on <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b1, "ext source");
    run_tap(7, 8);
    external_clock_on <= 1'b0;
    $display("source test done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h76);
    wait_mode <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, er} | rd, 32'h1, "wait blocked");
    apb(1'b1, 12'h000, 32'h0);
    wirq(200);
    wait_mode <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h76);
    stop_mode <= 1'b1;
    repeat (300) @(posedge pclk);
    chk(tick_irq, 1'b0, "stop idle");
    apb(1'b0, 12'h000, 32'h0);
    chk(er, 1'b1, "stop blocked");
    osc_keep_in_stop <= 1'b1;
    wirq(200);
    stop_mode <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    stop_mode <= 1'b1;
    repeat (100) @(posedge pclk);
    chk(tick_irq, 1'b0, "off in stop");
    stop_mode <= 1'b0;
    osc_keep_in_stop <= 1'b0;
    $display("low power test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "second reset");
    chk(tick_irq, 1'b0, "irq after reset");
    $display("reset test done");
    results();
  end
endmodule // ptt_timebase_test
